// >>> rtl/alx_exec.sv
// Execution unit for auto-indexed loads, word move, multiply and dispatch
`default_nettype none
module alx_exec
  import alx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [3:0]  pair_field,
  input  wire logic [15:0] working_pair,
  input  wire logic [7:0]  src_byte,
  input  wire logic [7:0]  mcand_even,
  input  wire logic [7:0]  unsigned_product_op_src,
  input  wire logic [15:0] word_src,
  input  wire logic [15:0] thread_pointer,
  input  wire logic [7:0]  flags_in,
  input  wire logic [7:0]  mem_rdata,
  output var  logic        busy,
  output var  logic        done,
  output var  logic        mem_rd,
  output var  logic        mem_wr,
  output var  logic        mem_xdata,
  output var  logic [15:0] mem_addr,
  output var  logic [7:0]  mem_wdata,
  output var  logic        dst_we,
  output var  logic [7:0]  dst_data,
  output var  logic        pair_we,
  output var  logic [15:0] pair_out,
  output var  logic        word_we,
  output var  logic [15:0] word_out,
  output var  logic        flags_we,
  output var  logic [7:0]  flags_out,
  output var  logic        pc_we,
  output var  logic [15:0] pc_out,
  output var  logic        tptr_we,
  output var  logic [15:0] tptr_out
);

  alx_state_t  state, next_state;
  logic [4:0]  cnt, next_cnt;
  logic [7:0]  op, next_op;
  logic [15:0] pair, next_pair;
  logic        xsp, next_xsp;
  logic [7:0]  sbyte, next_sbyte;
  logic [7:0]  mcand, next_mcand;
  logic [7:0]  msrc, next_msrc;
  logic [15:0] wsrc, next_wsrc;
  logic [15:0] tptr, next_tptr;
  logic [7:0]  flg, next_flg;
  logic [7:0]  rhi, next_rhi;
  logic [7:0]  rlo, next_rlo;
  logic        next_busy, next_done, next_mem_rd, next_mem_wr;
  logic        next_mem_xdata;
  logic [15:0] next_mem_addr;
  logic [7:0]  next_mem_wdata;
  logic        next_dst_we, next_pair_we, next_word_we;
  logic        next_flags_we, next_pc_we, next_tptr_we;
  logic [7:0]  next_dst_data, next_flags_out;
  logic [15:0] next_pair_out, next_word_out, next_pc_out, next_tptr_out;

  logic [4:0]  total;
  logic        is_load, is_store, is_dec, is_word, is_unsigned_product_op, is_next;
  logic        start_ok;
  logic [15:0] pair_dec, pair_inc, pair_step, product;

  // Opcode classes and length of the latched instruction
  always_comb begin
    is_load  = (op == ALX_OP_LD_DEC) || (op == ALX_OP_LD_INC);
    is_store = (op == ALX_OP_ST_DEC) || (op == ALX_OP_ST_INC);
    is_dec   = (op == ALX_OP_LD_DEC) || (op == ALX_OP_ST_DEC);
    is_word  = (op == ALX_OP_WORD_RR) || (op == ALX_OP_WORD_IR) ||
               (op == ALX_OP_WORD_IM);
    is_unsigned_product_op  = (op == ALX_OP_MUL_R) || (op == ALX_OP_MUL_IR) ||
               (op == ALX_OP_MUL_IM);
    is_next  = (op == ALX_OP_NEXT);
    total    = ALX_CYC_NEXT;
    if (is_load) begin
      total = ALX_CYC_LOAD;
    end else if (is_store) begin
      total = ALX_CYC_STORE;
    end else if (is_word) begin
      total = ALX_CYC_WORD;
    end else if (is_unsigned_product_op) begin
      total = ALX_CYC_UNSIGNED_PRODUCT_OP;
    end
  end

  // Accepted opcodes; others are ignored while idle
  always_comb begin
    start_ok = 1'b0;
    case (opcode)
      ALX_OP_LD_DEC, ALX_OP_LD_INC, ALX_OP_ST_DEC, ALX_OP_ST_INC,
      ALX_OP_WORD_RR, ALX_OP_WORD_IR, ALX_OP_WORD_IM,
      ALX_OP_MUL_R, ALX_OP_MUL_IR, ALX_OP_MUL_IM, ALX_OP_NEXT: begin
        start_ok = start;
      end
      default: begin
        start_ok = 1'b0;
      end
    endcase
  end

  // Full 16-bit pair arithmetic and unsigned product
  always_comb begin
    pair_dec  = pair - ALX_ONE;
    pair_inc  = pair + ALX_ONE;
    pair_step = is_dec ? pair_dec : pair_inc;
    product   = {ALX_ZERO8, mcand} * {ALX_ZERO8, msrc};
  end

  // Sequencer next values
  always_comb begin
    next_state     = state;
    {next_cnt, next_op, next_pair, next_xsp, next_sbyte, next_mcand,
     next_msrc, next_wsrc, next_tptr, next_flg, next_rhi,
     next_rlo} = {cnt, op, pair, xsp, sbyte, mcand, msrc, wsrc, tptr,
                  flg, rhi, rlo};
    next_busy      = busy;
    // Write strobes and done are one-cycle pulses
    {next_done, next_mem_rd, next_mem_wr, next_dst_we, next_pair_we,
     next_word_we, next_pc_we, next_tptr_we} = '0;
    next_flags_we  = 1'b0;
    // Data outputs hold until their next write
    {next_mem_xdata, next_mem_addr, next_mem_wdata, next_dst_data} =
      {mem_xdata, mem_addr, mem_wdata, dst_data};
    {next_pair_out, next_word_out, next_flags_out, next_pc_out,
     next_tptr_out} = {pair_out, word_out, flags_out, pc_out, tptr_out};
    unique case (state)
      ALX_IDLE: begin
        if (start_ok) begin
          next_state = ALX_EXEC;
          next_cnt   = ALX_STEP_FIRST;
          next_busy  = 1'b1;
          next_op    = opcode;
          next_pair  = working_pair;
          next_xsp   = pair_field[0];
          next_sbyte = src_byte;
          next_mcand = mcand_even;
          next_msrc  = unsigned_product_op_src;
          next_wsrc  = word_src;
          next_tptr  = thread_pointer;
          next_flg   = flags_in;
        end
      end
      ALX_EXEC: begin
        next_cnt = cnt + ALX_STEP_FIRST;
        // First memory access of the instruction
        if (cnt == ALX_STEP_ACC) begin
          if (is_load) begin
            next_mem_rd    = 1'b1;
            next_mem_addr  = pair;
            next_mem_xdata = xsp;
          end else if (is_store) begin
            next_mem_wr    = 1'b1;
            next_mem_addr  = pair_step;
            next_mem_wdata = sbyte;
            next_mem_xdata = xsp;
          end else if (is_next) begin
            next_mem_rd    = 1'b1;
            next_mem_addr  = tptr;
            next_mem_xdata = 1'b0;
          end
        end
        // Read data arrives one cycle after the strobe
        if (cnt == ALX_STEP_CAP) begin
          next_rhi = mem_rdata;
        end
        if ((cnt == ALX_STEP_ACC2) && is_next) begin
          next_mem_rd    = 1'b1;
          next_mem_addr  = tptr + ALX_ONE;
          next_mem_xdata = 1'b0;
        end
        if (cnt == ALX_STEP_CAP2) begin
          next_rlo = mem_rdata;
        end
        // Results are written together as the fetch is released
        if (cnt == total) begin
          next_state = ALX_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          if (is_load) begin
            next_dst_we   = 1'b1;
            next_dst_data = rhi;
          end
          if (is_load || is_store) begin
            next_pair_we  = 1'b1;
            next_pair_out = pair_step;
          end
          if (is_word) begin
            next_word_we  = 1'b1;
            next_word_out = wsrc;
          end
          if (is_unsigned_product_op) begin
            next_word_we   = 1'b1;
            next_word_out  = product;
            next_flags_we  = 1'b1;
            next_flags_out = flg;
            next_flags_out[ALX_FLAG_C] = product > ALX_BYTE_MAX;
            next_flags_out[ALX_FLAG_Z] = product == 16'h0000;
            next_flags_out[ALX_FLAG_S] = product[15];
            next_flags_out[ALX_FLAG_V] = 1'b0;
          end
          if (is_next) begin
            next_pc_we    = 1'b1;
            next_pc_out   = {rhi, rlo};
            next_tptr_we  = 1'b1;
            next_tptr_out = tptr + ALX_TWO;
          end
        end
      end
    endcase
  end

  // State and output registers, frozen while ce is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ALX_IDLE;
      {cnt, op, pair, xsp, sbyte, mcand, msrc, wsrc, tptr, flg, rhi,
       rlo} <= '0;
      {busy, done, mem_rd, mem_wr, mem_xdata, mem_addr, mem_wdata,
       dst_we, dst_data, pair_we, pair_out, word_we, word_out} <= '0;
      {flags_we, flags_out, pc_we, pc_out, tptr_we, tptr_out} <= '0;
    end else if (ce) begin
      state <= next_state;
      {cnt, op, pair, xsp, sbyte, mcand, msrc, wsrc, tptr, flg, rhi,
       rlo} <= {next_cnt, next_op, next_pair, next_xsp, next_sbyte,
                next_mcand, next_msrc, next_wsrc, next_tptr, next_flg,
                next_rhi, next_rlo};
      {busy, done, mem_rd, mem_wr, mem_xdata, mem_addr, mem_wdata,
       dst_we, dst_data, pair_we, pair_out, word_we, word_out} <=
        {next_busy, next_done, next_mem_rd, next_mem_wr, next_mem_xdata,
         next_mem_addr, next_mem_wdata, next_dst_we, next_dst_data,
         next_pair_we, next_pair_out, next_word_we, next_word_out};
      {flags_we, flags_out, pc_we, pc_out, tptr_we, tptr_out} <=
        {next_flags_we, next_flags_out, next_pc_we, next_pc_out,
         next_tptr_we, next_tptr_out};
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !ce);
  logic acc_ld, acc_st, acc_wd, acc_ml;
  assign acc_ld = (state == ALX_IDLE) && start_ok &&
                  ((opcode == ALX_OP_LD_DEC) || (opcode == ALX_OP_LD_INC));
  assign acc_st = (state == ALX_IDLE) && start_ok &&
                  ((opcode == ALX_OP_ST_DEC) || (opcode == ALX_OP_ST_INC));
  assign acc_wd = (state == ALX_IDLE) && start_ok &&
                  (opcode == ALX_OP_WORD_RR);
  assign acc_ml = (state == ALX_IDLE) && start_ok && (opcode == ALX_OP_MUL_R);

  chk_load_len_done: assert property (
    acc_ld |=> busy [*8] ##1 busy [*2] ##1 (done && !busy))
    else $error("load length wrong");
  chk_store_len_done: assert property (
    acc_st |-> ##15 (done && pair_we))
    else $error("store length wrong");
  chk_word_len_done: assert property (
    acc_wd |-> ##9 (done && word_we && word_out == $past(word_src, 9)))
    else $error("word move wrong");
  chk_unsigned_product_op_len_done: assert property (
    acc_ml |-> ##23 (done && word_we && flags_we))
    else $error("multiply length wrong");
  chk_pair_step_val: assert property (
    pair_we |-> pair_out == (is_dec ? pair - ALX_ONE : pair + ALX_ONE))
    else $error("pair step wrong");
  chk_store_addr_pre: assert property (
    (mem_wr && is_store) |-> (mem_addr == pair_step) && (mem_wdata == sbyte))
    else $error("store address wrong");
  chk_space_sel_odd: assert property (
    ((mem_rd || mem_wr) && !is_next) |-> mem_xdata == xsp)
    else $error("memory space wrong");
  chk_flags_only_unsigned_product_op: assert property (
    flags_we |-> is_unsigned_product_op)
    else $error("flags written by non-multiply");
  chk_unsigned_product_op_carry_flag: assert property (
    flags_we |-> flags_out[ALX_FLAG_C] == (word_out > ALX_BYTE_MAX))
    else $error("carry flag wrong");
  chk_unsigned_product_op_zs_flags: assert property (
    flags_we |-> (flags_out[ALX_FLAG_Z] == (word_out == 16'h0000)) &&
                 (flags_out[ALX_FLAG_S] == word_out[15]) &&
                 !flags_out[ALX_FLAG_V])
    else $error("zero or sign flag wrong");
  chk_dst_only_load: assert property (
    dst_we |-> is_load && (dst_data == rhi))
    else $error("destination written by wrong op");
  chk_next_ptr_adv: assert property (
    pc_we |-> tptr_we && (tptr_out == tptr + ALX_TWO) &&
              (pc_out == {rhi, rlo}))
    else $error("dispatch pointer wrong");

  cov_load_run: cover property (acc_ld ##11 done);
  cov_store_run: cover property (acc_st ##15 done);
  cov_unsigned_product_op_big: cover property (flags_we && flags_out[ALX_FLAG_C]);
  cov_next_run: cover property (pc_we && tptr_we);
endmodule
`default_nettype wire

// >>> rtl/alx_pkg.sv
// Constants, encodings and cycle counts for the auto-index execution unit
// Operation
// - Post-decrement load: byte at pair to register, pair - 1, 10 cycles
// - Post-increment load: byte at pair to register, pair + 1, 10 cycles
// - Pre-decrement store: pair - 1, then write register there; 14 cycles
// - Pre-increment store: pair + 1, then write register there; 14 cycles
// - Each auto-indexed transfer goes to program or external data memory
// - Even pair field means program memory, odd means external data
// - Source of a transfer is untouched; only destination and pair change
// - Transfers, word move and threaded dispatch leave all flags alone
// - Word move copies 16-bit source to destination pair in 8 cycles
// - Unsigned multiply stores full 16-bit product, takes 22 cycles
// - Multiplicand is the even register of the destination pair
// - Multiply sets carry flag when product exceeds 255, clears otherwise
// - Multiply sets zero and sign flags, clears overflow, keeps D and H
// - Dispatch loads the program counter from program word at pointer
// - Threaded dispatch then advances the thread pointer by two
`default_nettype none
package alx_pkg;

  // Opcodes
  localparam logic [7:0] ALX_OP_LD_DEC   = 8'hE2;
  localparam logic [7:0] ALX_OP_LD_INC   = 8'hE3;
  localparam logic [7:0] ALX_OP_ST_DEC   = 8'hF2;
  localparam logic [7:0] ALX_OP_ST_INC   = 8'hF3;
  localparam logic [7:0] ALX_OP_WORD_RR  = 8'hC4;
  localparam logic [7:0] ALX_OP_WORD_IR  = 8'hC5;
  localparam logic [7:0] ALX_OP_WORD_IM  = 8'hC6;
  localparam logic [7:0] ALX_OP_MUL_R    = 8'h84;
  localparam logic [7:0] ALX_OP_MUL_IR   = 8'h85;
  localparam logic [7:0] ALX_OP_MUL_IM   = 8'h86;
  localparam logic [7:0] ALX_OP_NEXT     = 8'h0F;

  // Execution lengths in clock cycles
  localparam logic [4:0] ALX_CYC_LOAD    = 5'h0A;
  localparam logic [4:0] ALX_CYC_STORE   = 5'h0E;
  localparam logic [4:0] ALX_CYC_WORD    = 5'h08;
  localparam logic [4:0] ALX_CYC_UNSIGNED_PRODUCT_OP    = 5'h16;
  localparam logic [4:0] ALX_CYC_NEXT    = 5'h0A;

  // Step numbers inside an instruction
  localparam logic [4:0] ALX_STEP_FIRST  = 5'h01;
  localparam logic [4:0] ALX_STEP_ACC    = 5'h01;
  localparam logic [4:0] ALX_STEP_CAP    = 5'h03;
  localparam logic [4:0] ALX_STEP_ACC2   = 5'h03;
  localparam logic [4:0] ALX_STEP_CAP2   = 5'h05;

  // Flag byte layout
  localparam int ALX_FLAG_C = 7;
  localparam int ALX_FLAG_Z = 6;
  localparam int ALX_FLAG_S = 5;
  localparam int ALX_FLAG_V = 4;

  // Pointer steps and limits
  localparam logic [15:0] ALX_ONE       = 16'h0001;
  localparam logic [15:0] ALX_TWO       = 16'h0002;
  localparam logic [15:0] ALX_BYTE_MAX  = 16'h00FF;
  localparam logic [7:0]  ALX_ZERO8     = 8'h00;

  typedef enum logic [1:0] {
    ALX_IDLE = 2'b01,
    ALX_EXEC = 2'b10
  } alx_state_t;

endpackage
`default_nettype wire

// >>> test/alx_mem_model.sv
// Program and external data memory seen from the execution unit
`default_nettype none
module alx_mem_model
(
  input  wire logic        clk_sys,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_xdata,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata,
  output var  logic [15:0] wr_addr,
  output var  logic [7:0]  wr_data,
  output var  logic        wr_xdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] pmem [logic [15:0]];
  logic [7:0] xmem [logic [15:0]];

  // Stored byte, or a fill pattern where nothing was written
  function automatic logic [7:0] rd_byte(input logic [15:0] a,
                                         input logic x);
    if (x && xmem.exists(a)) return xmem[a];
    if (!x && pmem.exists(a)) return pmem[a];
    return a[15:8] ^ a[7:0] ^ (x ? 8'hA5 : 8'h3C);
  endfunction

  initial begin
    mem_rdata = 8'h00;
    wr_addr = 16'h0000;
    wr_data = 8'h00;
    wr_xdata = 1'b0;
  end

  // Data one cycle after the strobe, a changing filler otherwise
  always @(posedge clk_sys) begin
    if (mem_rd) begin
      mem_rdata <= rd_byte(mem_addr, mem_xdata);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr) begin
      if (mem_xdata) xmem[mem_addr] = mem_wdata;
      else pmem[mem_addr] = mem_wdata;
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_xdata <= mem_xdata;
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the auto-index execution unit
`default_nettype none
module testbench
  import alx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        start = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [3:0]  pair_field = 4'h0;
  logic [15:0] working_pair = 16'h0000;
  logic [7:0]  src_byte = 8'h00;
  logic [7:0]  mcand_even = 8'h00;
  logic [7:0]  unsigned_product_op_src = 8'h00;
  logic [15:0] word_src = 16'h0000;
  logic [15:0] thread_pointer = 16'h0000;
  logic [7:0]  flags_in = 8'h00;
  logic [7:0]  mem_rdata, mem_wdata, dst_data, flags_out, wr_data;
  logic [15:0] mem_addr, pair_out, word_out, pc_out, tptr_out, wr_addr;
  logic        busy, done, mem_rd, mem_wr, mem_xdata, dst_we, pair_we;
  logic        word_we, flags_we, pc_we, tptr_we, wr_xdata, any_out;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          cnt, ngap;
  logic [15:0] pk, a_first, pr, ea, wv, p;
  logic [7:0]  sb, fl;
  logic [3:0]  pf;
  logic        x_any;
  logic [15:0] mt [6] = '{16'h2009, 16'h005A, 16'hFFFF, 16'h100F,
                          16'h01FF, 16'h8001};

  alx_exec alx_exec_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .start(start), .opcode(opcode), .pair_field(pair_field),
    .working_pair(working_pair), .src_byte(src_byte),
    .mcand_even(mcand_even), .unsigned_product_op_src(unsigned_product_op_src), .word_src(word_src),
    .thread_pointer(thread_pointer), .flags_in(flags_in),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_xdata(mem_xdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .dst_we(dst_we), .dst_data(dst_data),
    .pair_we(pair_we), .pair_out(pair_out), .word_we(word_we),
    .word_out(word_out), .flags_we(flags_we), .flags_out(flags_out),
    .pc_we(pc_we), .pc_out(pc_out), .tptr_we(tptr_we),
    .tptr_out(tptr_out));

  alx_mem_model alx_mem_model_inst (.clk_sys(clk_sys), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_xdata(mem_xdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_xdata(wr_xdata));

  assign any_out = |{busy, done, mem_rd, mem_wr, dst_we, pair_we, word_we,
                     flags_we, pc_we, tptr_we, mem_addr, pc_out};

  always #25 clk_sys = ~clk_sys;

  // Cut a hung run short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  // Expected contents of a location never written
  function automatic logic [7:0] pat_byte(input logic [15:0] a,
                                          input logic x);
    return a[15:8] ^ a[7:0] ^ (x ? 8'hA5 : 8'h3C);
  endfunction

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("ERROR %0t cycles got %0d expected %0d", $time, got, exp);
    end
  endtask

  // One instruction; mode 1 pokes start while busy, mode 2 stalls ce
  task automatic run_op(input logic [7:0] op, input logic [3:0] f,
      input logic [15:0] wp, input logic [7:0] s, input logic [7:0] mc,
      input logic [7:0] ms, input logic [15:0] w, input logic [15:0] tp,
      input logic [7:0] fi, input int mode);
    int fz;
    int pulses [8];
    logic ce_e;
    logic seen;
    logic [7:0] pv;
    fz = 0;
    pulses = '{default: 0};
    seen = 1'b0;
    x_any = 1'b0;
    ngap = 0;
    opcode = op;
    pair_field = f;
    working_pair = wp;
    src_byte = s;
    mcand_even = mc;
    unsigned_product_op_src = ms;
    word_src = w;
    thread_pointer = tp;
    flags_in = fi;
    start = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    start = 1'b0;
    cnt = 0;
    while (done !== 1'b1 && cnt < 40) begin
      @(posedge clk_sys);
      ce_e = ce;
      if (ce_e) cnt++;
      @(negedge clk_sys);
      if (ce_e) begin
        pv = {tptr_we, pc_we, word_we, pair_we, dst_we, flags_we, mem_wr,
              mem_rd};
        for (int i = 0; i < 8; i++) pulses[i] += int'(pv[i]);
        if ((mem_rd || mem_wr) && !seen) a_first = mem_addr;
        if (mem_rd || mem_wr) seen = 1'b1;
        if (mem_rd || mem_wr) x_any = x_any | mem_xdata;
        if (done !== 1'b1 && busy !== 1'b1) ngap++;
      end
      if (mode == 1 && (cnt == 3 || cnt == 4)) begin
        start  = (cnt == 3);
        opcode = (cnt == 3) ? ALX_OP_MUL_R : op;
      end
      ce = !(mode == 2 && cnt >= 5 && fz < 4);
      if (!ce) fz++;
    end
    // Two bits per strobe: rd wr flags dst pair word pc tptr
    pk = 16'h0000;
    for (int i = 0; i < 8; i++) pk[2*i +: 2] = (pulses[i] > 3) ? 2'h3 :
                                                2'(pulses[i]);
  endtask

  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    check_val({15'h0000, any_out}, 16'h0000);
    rst = 1'b0;
    // Loads across a borrow and a carry, both spaces, poke and stall
    for (int i = 0; i < 4; i++) begin
      pr = i[0] ? 16'h21FF : 16'h1000;
      pf = i[1] ? 4'h7 : 4'h6;
      run_op(i[0] ? ALX_OP_LD_INC : ALX_OP_LD_DEC, pf, pr, 8'h00, 8'h00,
             8'h00, 16'h0000, 16'h0000, 8'hFF, (i > 1) ? i - 1 : 0);
      check_cnt(cnt, 10);
      check_val(pk, 16'h0141);
      check_val(a_first, pr);
      check_val({15'h0000, x_any}, {15'h0000, pf[0]});
      check_val({8'h00, dst_data}, {8'h00, pat_byte(pr, pf[0])});
      check_val(pair_out, i[0] ? pr + 16'h0001 : pr - 16'h0001);
    end
    $display("test loads done");
    // Stores with pointer step first, then read back
    for (int i = 0; i < 4; i++) begin
      pr = i[0] ? 16'h21FF : 16'h3000;
      pf = i[1] ? 4'h7 : 4'h6;
      sb = i[0] ? 8'h7F : 8'h77;
      ea = i[0] ? pr + 16'h0001 : pr - 16'h0001;
      run_op(i[0] ? ALX_OP_ST_INC : ALX_OP_ST_DEC, pf, pr, sb, 8'h00,
             8'h00, 16'h0000, 16'h0000, 8'hFF, 0);
      check_cnt(cnt, 14);
      check_val(pk, 16'h0104);
      check_val(wr_addr, ea);
      check_val(pair_out, ea);
      check_val({7'h00, wr_xdata, wr_data}, {7'h00, pf[0], sb});
      run_op(ALX_OP_LD_INC, pf, ea, 8'h00, 8'h00, 8'h00, 16'h0000,
             16'h0000, 8'h00, 0);
      check_val({8'h00, dst_data}, {8'h00, sb});
    end
    $display("test stores done");
    // Word move in all three forms
    for (int i = 0; i < 3; i++) begin
      wv = (i == 0) ? 16'h061C : (i == 1) ? 16'h030F : 16'h1234;
      run_op(ALX_OP_WORD_RR + 8'(i), 4'h0, 16'h0000, 8'h00, 8'h00, 8'h00,
             wv, 16'h0000, 8'hFF, 0);
      check_cnt(cnt, 8);
      check_cnt(ngap, 0);
      check_val(pk, 16'h0400);
      check_val(word_out, wv);
    end
    $display("test word done");
    // Multiply: carry, zero and sign edges, every form
    for (int i = 0; i < 6; i++) begin
      fl = i[0] ? 8'hFC : 8'h13;
      p = {8'h00, mt[i][15:8]} * {8'h00, mt[i][7:0]};
      run_op(ALX_OP_MUL_R + 8'(i % 3), 4'h0, 16'h0000, 8'h00, mt[i][15:8],
             mt[i][7:0], 16'h0000, 16'h0000, fl, (i == 5) ? 2 : 0);
      check_cnt(cnt, 22);
      check_val(pk, 16'h0410);
      check_val(word_out, p);
      check_val({8'h00, flags_out}, {8'h00, p > 16'h00FF, p == 16'h0000,
                p[15], 1'b0, fl[3:0]});
    end
    $display("test multiply done");
    // Threaded dispatch, including pointer wrap
    for (int i = 0; i < 2; i++) begin
      pr = i[0] ? 16'hFFFE : 16'h0100;
      run_op(ALX_OP_NEXT, 4'h7, 16'h0000, 8'h00, 8'h00, 8'h00, 16'h0000,
             pr, 8'hFF, 0);
      check_cnt(cnt, 10);
      check_val(pk, 16'h5002);
      check_val(a_first, pr);
      check_val({15'h0000, x_any}, 16'h0000);
      check_val(pc_out, {pat_byte(pr, 1'b0),
                         pat_byte(pr + 16'h0001, 1'b0)});
      check_val(tptr_out, pr + 16'h0002);
    end
    $display("test dispatch done");
    // Undefined opcode starts nothing
    run_op(8'h00, 4'h0, 16'h1234, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000,
           8'hFF, 0);
    check_cnt(cnt, 40);
    check_val(pk, 16'h0000);
    $display("test undefined done");
    finish_test();
  end
endmodule
`default_nettype wire
